//--- core/pod_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "pod_cfg.svh"

module pod_decoder (
   input wire logic clock,
   input wire logic resetn,
   input wire logic odWrite,
   input wire logic odRead,
   input wire logic [15:0] odIndex,
   input wire logic [7:0] odSubindex,
   input wire logic [31:0] odWriteData,
   output logic odDone,
   output logic odAbort,
   output logic [31:0] odReadData,
   input wire logic [15:0] controlWord,
   input wire logic targetReached,
   input wire logic signed [31:0] requestedTarget,
   input wire logic signed [31:0] rampPosition,
   input wire logic signed [31:0] actualPosition,
   input wire logic signed [31:0] minLimit,
   input wire logic signed [31:0] maxLimit,
   output logic newSetpointClear,
   output logic setpointAck,
   output logic signed [31:0] targetPosition,
   output logic moveDirPositive,
   output logic moveWraps,
   output logic longMoveAllowed,
   output logic [1:0] changeImmediateSel,
   output logic [3:0] interpolationOption,
   output logic vendorSpecificBit,
   input wire logic feedStart,
   input wire logic [1:0] feedSelect,
   input wire logic [31:0] feedValue,
   output logic feedBusy,
   output logic feedDone,
   output logic feedSkipped,
   output logic [31:0] feedConstant
);
   logic [15:0] optWord;
   logic nsPrev;
   logic busySeen;
   logic signed [31:0] prevTarget;
   pod_pkg::pod_hs_t state;
   pod_pkg::pod_release_t latRelease;
   logic readFromMem;
   logic [31:0] localRead;
   logic [1:0] feedPend;
   logic [1:0] feedSelLat;
   logic [31:0] feedValLat;
   logic [31:0] memReadA;
   logic [31:0] memReadB;
   logic divBusy;

   // ----------------------------------------------------------------------
   // Option word decode
   // ----------------------------------------------------------------------
   pod_pkg::pod_rel_t relBaseSelect;
   pod_pkg::pod_release_t releaseSelect;
   pod_pkg::pod_dir_t rotationDirectionSelect;
   pod_pkg::pod_rel_t relEff;
   pod_pkg::pod_release_t releaseEff;
   assign relBaseSelect = pod_pkg::pod_rel_t'(optWord[`POD_REL_LSB +: 2]);
   assign releaseSelect = pod_pkg::pod_release_t'(optWord[`POD_RRO_LSB +: 2]);
   assign rotationDirectionSelect = pod_pkg::pod_dir_t'(optWord[`POD_DIR_LSB +: 2]);
   assign changeImmediateSel = optWord[`POD_CIC_LSB +: 2];
   assign interpolationOption = optWord[`POD_IPO_LSB +: 4];
   assign vendorSpecificBit = optWord[`POD_MS_BIT];
   assign relEff = (relBaseSelect == pod_pkg::POD_REL_RSVD) ? pod_pkg::POD_REL_PREV
      : relBaseSelect;
   assign releaseEff = (releaseSelect == pod_pkg::POD_RLS_RSVD) ? pod_pkg::POD_RLS_MASTER
      : releaseSelect;

   // ----------------------------------------------------------------------
   // Object dictionary access
   // ----------------------------------------------------------------------
   wire odAccess = odWrite || odRead;
   wire hitOpt = odIndex == `POD_IDX_OPT && odSubindex == 8'h00;
   wire hitCount = odIndex == `POD_IDX_REVS && odSubindex == 8'h00;
   wire hitEntry = odIndex == `POD_IDX_REVS && odSubindex != 8'h00
      && odSubindex <= `POD_FEEDBACKS;
   wire badAccess = odAccess && (!(hitOpt || hitCount || hitEntry)
      || (odWrite && odRead) || (odWrite && hitCount));
   wire goodWrite = odWrite && !badAccess;
   wire [1:0] entryAddr = odSubindex[1:0] - 2'h1;
   wire [31:0] nextLocal = hitOpt ? {16'h0000, optWord}
      : hitCount ? {24'h000000, `POD_FEEDBACKS} : 32'h00000000;
   assign odReadData = readFromMem ? memReadA : localRead;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         optWord <= `POD_OPT_RESET;
         odDone <= 1'b0;
         odAbort <= 1'b0;
         readFromMem <= 1'b0;
         localRead <= 32'h00000000;
      end else begin
         odDone <= odAccess;
         odAbort <= badAccess;
         readFromMem <= odRead && hitEntry && !badAccess;
         localRead <= (odRead && !badAccess) ? nextLocal : 32'h00000000;
         if (goodWrite && hitOpt) begin
            optWord <= odWriteData[15:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Target resolution and direction policy
   // ----------------------------------------------------------------------
   wire nsBit = controlWord[`POD_CW_NEWSP];
   wire relBit = controlWord[`POD_CW_REL];
   wire accept = state == pod_pkg::POD_HS_IDLE && nsBit && !nsPrev;
   wire signed [31:0] relBase = (relEff == pod_pkg::POD_REL_RAMP) ? rampPosition
      : (relEff == pod_pkg::POD_REL_ACTUAL) ? actualPosition : prevTarget;
   wire signed [31:0] rawTarget = relBit ? 32'(relBase + requestedTarget)
      : requestedTarget;
   logic signed [32:0] wRaw;
   logic signed [32:0] wMin;
   logic signed [32:0] wMax;
   logic signed [32:0] wAct;
   assign wRaw = {rawTarget[31], rawTarget};
   assign wMin = {minLimit[31], minLimit};
   assign wMax = {maxLimit[31], maxLimit};
   assign wAct = {actualPosition[31], actualPosition};
   wire limitsOn = wMax > wMin;
   wire signed [32:0] span = wMax - wMin + 33'sh000000001;
   // Only one wrap is applied, so a preset more than a range beyond the limit stays outside.
   wire signed [32:0] linTarget = !limitsOn ? wRaw : (wRaw > wMax) ? wRaw - span
      : (wRaw < wMin) ? wRaw + span : wRaw;
   wire isLinear = rotationDirectionSelect == pod_pkg::POD_DIR_LINEAR;
   wire signed [31:0] finalTarget = isLinear ? linTarget[31:0] : rawTarget;
   wire signed [32:0] diff = {finalTarget[31], finalTarget} - wAct;
   wire signed [32:0] ahead = diff[32] ? diff + span : diff;
   wire shortPos = ahead < (span >>> 1);
   logic nextDirPos;
   logic nextWraps;

   always_comb begin
      unique case (rotationDirectionSelect)
         pod_pkg::POD_DIR_LINEAR: begin
            nextDirPos = finalTarget >= actualPosition;
            nextWraps = linTarget != wRaw;
         end
         pod_pkg::POD_DIR_NEG: begin
            nextDirPos = 1'b0;
            nextWraps = finalTarget > actualPosition;
         end
         pod_pkg::POD_DIR_POS: begin
            nextDirPos = 1'b1;
            nextWraps = finalTarget < actualPosition;
         end
         pod_pkg::POD_DIR_SHORT: begin
            nextDirPos = shortPos;
            nextWraps = shortPos ? finalTarget < actualPosition : finalTarget > actualPosition;
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prevTarget <= 32'sh00000000;
         targetPosition <= 32'sh00000000;
         moveDirPositive <= 1'b1;
         moveWraps <= 1'b0;
         longMoveAllowed <= 1'b1;
      end else if (accept) begin
         prevTarget <= finalTarget;
         targetPosition <= finalTarget;
         moveDirPositive <= nextDirPos;
         moveWraps <= nextWraps;
         longMoveAllowed <= isLinear;
      end
   end

   // ----------------------------------------------------------------------
   // New-setpoint handshake
   // ----------------------------------------------------------------------
   // The reached flag may still be high from the last move, so a low level must be seen first.
   wire reachedNow = latRelease == pod_pkg::POD_RLS_REACHED && busySeen && targetReached;
   wire releaseNow = state == pod_pkg::POD_HS_ACKED
      && (reachedNow || latRelease == pod_pkg::POD_RLS_EARLY);
   wire masterDrop = state == pod_pkg::POD_HS_ACKED
      && latRelease == pod_pkg::POD_RLS_MASTER && !nsBit;
   assign newSetpointClear = releaseNow;
   assign setpointAck = state == pod_pkg::POD_HS_ACKED;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= pod_pkg::POD_HS_IDLE;
         latRelease <= pod_pkg::POD_RLS_MASTER;
         nsPrev <= 1'b0;
         busySeen <= 1'b0;
      end else begin
         nsPrev <= nsBit && !releaseNow;
         if (accept) begin
            state <= pod_pkg::POD_HS_ACKED;
            latRelease <= releaseEff;
            busySeen <= 1'b0;
         end else if (releaseNow || masterDrop) begin
            state <= pod_pkg::POD_HS_IDLE;
         end else if (state == pod_pkg::POD_HS_ACKED && !targetReached) begin
            busySeen <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Revolutions array and feed constant
   // ----------------------------------------------------------------------
   // Two idle cycles let the registered divisor read settle before the divider starts.
   wire feedTake = feedStart && !feedBusy;
   assign feedBusy = feedPend != 2'b00 || divBusy;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         feedPend <= 2'b00;
         feedSelLat <= 2'b00;
         feedValLat <= 32'h00000000;
      end else begin
         feedPend <= {feedPend[0], feedTake};
         if (feedTake) begin
            feedSelLat <= feedSelect;
            feedValLat <= feedValue;
         end
      end
   end

   pod_rev_mem u_mem (
      .clock(clock),
      .resetn(resetn),
      .writeEn(goodWrite && hitEntry),
      .writeAddr(entryAddr),
      .writeData(odWriteData),
      .readAddrA(entryAddr),
      .readDataA(memReadA),
      .readAddrB(feedSelLat - 2'h1),
      .readDataB(memReadB)
   );

   pod_feed_div u_div (
      .clock(clock),
      .resetn(resetn),
      .start(feedPend[1]),
      .dividend(feedValLat),
      .divisor(memReadB),
      .busy(divBusy),
      .done(feedDone),
      .skipped(feedSkipped),
      .quotient(feedConstant)
   );

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   property p_rel(pod_pkg::pod_rel_t sel, logic signed [31:0] base);
      accept && relBit && relBaseSelect == sel && !isLinear
         |=> targetPosition == $past(base) + $past(requestedTarget);
   endproperty

   a_abs_target: assert property (accept && !relBit && !isLinear
      |=> targetPosition == $past(requestedTarget)) else $error("absolute target altered");
   a_rel_prev: assert property (p_rel(pod_pkg::POD_REL_PREV, prevTarget))
      else $error("relative to previous target wrong");
   a_rel_ramp: assert property (p_rel(pod_pkg::POD_REL_RAMP, rampPosition))
      else $error("relative to ramp output wrong");
   a_rel_actual: assert property (p_rel(pod_pkg::POD_REL_ACTUAL, actualPosition))
      else $error("relative to actual position wrong");
   a_rel_reserved: assert property (p_rel(pod_pkg::POD_REL_RSVD, prevTarget))
      else $error("reserved base not treated as 00");
   a_clear_ack: assert property (newSetpointClear |=> !setpointAck)
      else $error("acknowledge kept after clear");
   a_master_release: assert property (latRelease == pod_pkg::POD_RLS_MASTER
      |-> !newSetpointClear) else $error("device cleared bit in master mode");
   a_reached_release: assert property ($rose(targetReached) && $past(setpointAck)
      && setpointAck && latRelease == pod_pkg::POD_RLS_REACHED |-> newSetpointClear)
      else $error("no release at target reached");
   a_early_release: assert property (accept && releaseEff == pod_pkg::POD_RLS_EARLY
      |=> newSetpointClear ##1 !setpointAck) else $error("early release late");
   a_long_move: assert property (accept
      |=> longMoveAllowed == ($past(rotationDirectionSelect) == pod_pkg::POD_DIR_LINEAR))
      else $error("long move permission wrong");
   a_neg_only: assert property (accept && rotationDirectionSelect == pod_pkg::POD_DIR_NEG
      |=> !moveDirPositive && moveWraps == (targetPosition > $past(actualPosition)))
      else $error("negative-only policy broken");
   a_pos_only: assert property (accept && rotationDirectionSelect == pod_pkg::POD_DIR_POS
      |=> moveDirPositive && moveWraps == (targetPosition < $past(actualPosition)))
      else $error("positive-only policy broken");
   a_entry_count: assert property (odRead && !odWrite && hitCount
      |=> odDone && !odAbort && odReadData == 32'h00000003) else $error("entry count wrong");

   c_ramp_move: cover property (accept && relBit && relEff == pod_pkg::POD_REL_RAMP);
   c_early: cover property (newSetpointClear && latRelease == pod_pkg::POD_RLS_EARLY);
   c_short_neg: cover property (accept && rotationDirectionSelect == pod_pkg::POD_DIR_SHORT
      && !shortPos);
endmodule : pod_decoder

`default_nettype wire

//--- core/pod_cfg.svh
`ifndef POD_CFG_SVH
`define POD_CFG_SVH

// ----------------------------------------------------------------------
// Object dictionary map
// ----------------------------------------------------------------------
`define POD_IDX_REVS 16'h60ee
`define POD_IDX_OPT 16'h60f2
`define POD_OPT_RESET 16'h0001
`define POD_FEEDBACKS 8'h03
`define POD_REVS_RESET 32'h00000001

// ----------------------------------------------------------------------
// Option word fields
// ----------------------------------------------------------------------
`define POD_REL_LSB 0
`define POD_CIC_LSB 2
`define POD_RRO_LSB 4
`define POD_DIR_LSB 6
`define POD_IPO_LSB 8
`define POD_MS_BIT 15

// ----------------------------------------------------------------------
// Controlword bits
// ----------------------------------------------------------------------
`define POD_CW_NEWSP 4
`define POD_CW_REL 6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define POD_DIV_STEPS 6'h20

`endif

//--- core/pod_pkg.sv
package pod_pkg;
   typedef enum logic [1:0] {POD_REL_PREV, POD_REL_RAMP, POD_REL_ACTUAL, POD_REL_RSVD} pod_rel_t;
   typedef enum logic [1:0] {POD_RLS_MASTER, POD_RLS_REACHED, POD_RLS_EARLY, POD_RLS_RSVD}
      pod_release_t;
   typedef enum logic [1:0] {POD_DIR_LINEAR, POD_DIR_NEG, POD_DIR_POS, POD_DIR_SHORT} pod_dir_t;
   typedef enum logic {POD_HS_IDLE, POD_HS_ACKED} pod_hs_t;
endpackage : pod_pkg

//--- core/pod_rev_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "pod_cfg.svh"

module pod_rev_mem (
   input wire logic clock,
   input wire logic resetn,
   input wire logic writeEn,
   input wire logic [1:0] writeAddr,
   input wire logic [31:0] writeData,
   input wire logic [1:0] readAddrA,
   output logic [31:0] readDataA,
   input wire logic [1:0] readAddrB,
   output logic [31:0] readDataB
);
   // Entry 0 is the sensorless feedback, the rest follow the sensor order.
   logic [31:0] entry [4];

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_entry
         if (i < 3) begin : g_live
            always_ff @(posedge clock or negedge resetn) begin
               if (!resetn) begin
                  entry[i] <= `POD_REVS_RESET;
               end else if (writeEn && writeAddr == 2'(i)) begin
                  entry[i] <= writeData;
               end
            end
         end else begin : g_none
            // An address past the last feedback reads zero.
            assign entry[i] = 32'h00000000;
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         readDataA <= 32'h00000000;
         readDataB <= 32'h00000000;
      end else begin
         readDataA <= entry[readAddrA];
         readDataB <= entry[readAddrB];
      end
   end
endmodule : pod_rev_mem

`default_nettype wire

//--- core/pod_feed_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "pod_cfg.svh"

module pod_feed_div (
   input wire logic clock,
   input wire logic resetn,
   input wire logic start,
   input wire logic [31:0] dividend,
   input wire logic [31:0] divisor,
   output logic busy,
   output logic done,
   output logic skipped,
   output logic [31:0] quotient
);
   logic [31:0] dvd;
   logic [31:0] dvs;
   logic [31:0] rem;
   logic [5:0] count;
   logic [31:0] origDvd;
   logic [31:0] origDvs;
   wire [33:0] shifted = {1'b0, rem, dvd[31]};
   wire [33:0] trial = shifted - {2'b00, dvs};
   wire fits = !trial[33];

   // ----------------------------------------------------------------------
   // Restoring division, one quotient bit per cycle
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         done <= 1'b0;
         skipped <= 1'b0;
         quotient <= 32'h00000000;
         dvd <= 32'h00000000;
         dvs <= 32'h00000000;
         rem <= 32'h00000000;
         count <= 6'h00;
      end else begin
         done <= 1'b0;
         skipped <= 1'b0;
         if (!busy && start) begin
            // A zero divisor leaves the last feed constant untouched.
            if (divisor == 32'h00000000) begin
               skipped <= 1'b1;
            end else begin
               busy <= 1'b1;
               dvd <= dividend;
               dvs <= divisor;
               rem <= 32'h00000000;
               count <= `POD_DIV_STEPS;
            end
         end else if (busy) begin
            rem <= fits ? trial[31:0] : shifted[31:0];
            dvd <= {dvd[30:0], fits};
            count <= count - 6'h01;
            if (count == 6'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
               quotient <= {dvd[30:0], fits};
            end
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         origDvd <= 32'h00000000;
         origDvs <= 32'h00000001;
      end else if (!busy && start) begin
         origDvd <= dividend;
         origDvs <= divisor;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_div_result: assert property (done |-> quotient == origDvd / origDvs)
      else $error("feed constant quotient wrong");
   a_zero_skip: assert property (!busy && start && divisor == 32'h00000000 |=>
      skipped && !busy && quotient == $past(quotient))
      else $error("zero divisor not skipped");
   c_div_done: cover property (done);
endmodule : pod_feed_div

`default_nettype wire

//--- verification/pod_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Master side of the new-setpoint handshake
// ----------------------------------------------------------------------
module pod_master_model (
   input wire logic clock,
   input wire logic resetn,
   input wire logic request,
   input wire logic newSetpointClear,
   output logic newSetpoint
);
   logic held;

   // A device clear keeps the bit low until the master withdraws its request,
   // so one request never produces a second rising edge.
   // The clear is sampled on the rising edge, because a release caused by the reached
   // input stands for only half a cycle before that edge.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         newSetpoint <= 1'b0;
         held <= 1'b0;
      end else if (newSetpointClear) begin
         newSetpoint <= 1'b0;
         held <= 1'b1;
      end else if (!request) begin
         newSetpoint <= 1'b0;
         held <= 1'b0;
      end else if (!held) begin
         newSetpoint <= 1'b1;
      end
   end
endmodule : pod_master_model

`default_nettype wire

//--- verification/test_positioning_option_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module test_positioning_option_decoder;
   // ----------------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------------
   logic clock = 1'b0, resetn = 1'b0, odWrite = 1'b0, odRead = 1'b0, request = 1'b0;
   logic targetReached = 1'b0, feedStart = 1'b0, newSetpoint, odDone, odAbort;
   logic newSetpointClear, setpointAck, moveDirPositive, moveWraps, longMoveAllowed;
   logic vendorSpecificBit, feedBusy, feedDone, feedSkipped;
   logic [15:0] odIndex = 16'h0000, cwRest = 16'h0000, controlWord;
   logic [7:0] odSubindex = 8'h00;
   logic [31:0] odWriteData = 32'h0, feedValue = 32'h0, rd, odReadData, feedConstant;
   logic [1:0] feedSelect = 2'h0, changeImmediateSel;
   logic [3:0] interpolationOption;
   logic signed [31:0] requestedTarget = 32'sh0, rampPosition = 32'sh1000;
   logic signed [31:0] actualPosition = 32'sh2000, minLimit = 32'sh0;
   logic signed [31:0] maxLimit = 32'shffff, targetPosition;
   int n_errors = 0, checks = 0;
   logic [15:0] masterOpts [2] = '{16'h0000, 16'h0030};

   assign controlWord = {cwRest[15:5], newSetpoint, cwRest[3:0]};
   always #4 clock = ~clock;

   pod_decoder uut (.clock, .resetn, .odWrite, .odRead, .odIndex, .odSubindex, .odWriteData,
      .odDone, .odAbort, .odReadData, .controlWord, .targetReached, .requestedTarget,
      .rampPosition, .actualPosition, .minLimit, .maxLimit, .newSetpointClear, .setpointAck,
      .targetPosition, .moveDirPositive, .moveWraps, .longMoveAllowed, .changeImmediateSel,
      .interpolationOption, .vendorSpecificBit, .feedStart, .feedSelect, .feedValue,
      .feedBusy, .feedDone, .feedSkipped, .feedConstant);
   pod_master_model master (.clock, .resetn, .request, .newSetpointClear, .newSetpoint);

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
         input logic [31:0] data, input logic expAbort);
      @(negedge clock);
      odWrite <= wr;
      odRead <= ~wr;
      odIndex <= idx;
      odSubindex <= sub;
      odWriteData <= data;
      @(negedge clock);
      odWrite <= 1'b0;
      odRead <= 1'b0;
      `CHK(odDone, 1'b1)
      `CHK(odAbort, expAbort)
      rd = odReadData;
   endtask : od

   task automatic move(input logic [15:0] opt, input logic [15:0] cw, input logic [31:0] t);
      od(1'b1, 16'h60f2, 8'h00, {16'h0000, opt}, 1'b0);
      cwRest <= cw;
      requestedTarget <= t;
      request <= 1'b1;
      repeat (2) @(negedge clock);
      `CHK(setpointAck, 1'b1)
   endtask : move

   task automatic drop;
      request <= 1'b0;
      repeat (2) @(negedge clock);
   endtask : drop

   task automatic early_close;
      `CHK(newSetpointClear, 1'b1)
      @(negedge clock);
      `CHK(setpointAck, 1'b0)
      drop;
   endtask : early_close

   task automatic feed(input logic [1:0] sel, input logic [31:0] value);
      @(negedge clock);
      feedSelect <= sel;
      feedValue <= value;
      feedStart <= 1'b1;
      @(negedge clock);
      feedStart <= 1'b0;
      `CHK(feedBusy, 1'b1)
      for (int i = 0; i < 40 && !(feedDone || feedSkipped); i++) @(negedge clock);
   endtask : feed

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_registers;
      od(1'b0, 16'h60f2, 8'h00, 32'h0, 1'b0);
      `CHK(rd, 32'h00000001)
      for (int s = 1; s < 4; s++) begin
         od(1'b0, 16'h60ee, s[7:0], 32'h0, 1'b0);
         `CHK(rd, 32'h00000001)
      end
      od(1'b1, 16'h60ee, 8'h00, 32'h5, 1'b1);
      od(1'b0, 16'h60ee, 8'h00, 32'h0, 1'b0);
      `CHK(rd, 32'h00000003)
      od(1'b1, 16'h60ee, 8'h03, 32'hfedcba98, 1'b0);
      od(1'b0, 16'h60ee, 8'h03, 32'h0, 1'b0);
      `CHK(rd, 32'hfedcba98)
      od(1'b0, 16'h60f0, 8'h00, 32'h0, 1'b1);
      od(1'b1, 16'h60f2, 8'h00, 32'h00008a2c, 1'b0);
      `CHK({vendorSpecificBit, interpolationOption, changeImmediateSel}, 7'h6b)
      $display("registers test done");
   endtask : t_registers

   task automatic t_relative;
      logic [31:0] exp [4] = '{32'h64, 32'h1064, 32'h2064, 32'h20c8};
      for (int b = 0; b < 4; b++) begin
         move(16'h00e0 | 16'(b), 16'h0040, 32'sh64);
         `CHK(targetPosition, exp[b])
         early_close;
      end
      move(16'h00e2, 16'h0000, 32'sh500);
      `CHK(targetPosition, 32'sh500)
      early_close;
      $display("relative test done");
   endtask : t_relative

   task automatic t_release;
      move(16'h0010, 16'h0000, 32'sh100);
      repeat (3) @(negedge clock);
      `CHK(newSetpointClear, 1'b0)
      targetReached <= 1'b1;
      // The release follows the reached input at once and is gone after the next rising edge.
      #1;
      `CHK(newSetpointClear, 1'b1)
      @(negedge clock);
      `CHK(setpointAck, 1'b0)
      drop;
      targetReached <= 1'b0;
      foreach (masterOpts[i]) begin
         move(masterOpts[i], 16'h0000, 32'sh200);
         repeat (4) @(negedge clock);
         `CHK({setpointAck, newSetpointClear}, 2'b10)
         drop;
         `CHK(setpointAck, 1'b0)
      end
      $display("release test done");
   endtask : t_release

   task automatic t_direction;
      maxLimit <= 32'sh167;
      actualPosition <= 32'sh64;
      move(16'h0020, 16'h0000, 32'sh190);
      `CHK({targetPosition, longMoveAllowed}, {32'sh28, 1'b1})
      early_close;
      move(16'h0060, 16'h0000, 32'shc8);
      `CHK({moveDirPositive, moveWraps, longMoveAllowed}, 3'b010)
      early_close;
      move(16'h00a0, 16'h0000, 32'sh32);
      `CHK({moveDirPositive, moveWraps}, 2'b11)
      early_close;
      move(16'h00e0, 16'h0000, 32'shc8);
      `CHK({moveDirPositive, longMoveAllowed}, 2'b10)
      early_close;
      move(16'h00e0, 16'h0000, 32'sh12c);
      `CHK(moveDirPositive, 1'b0)
      early_close;
      $display("direction test done");
   endtask : t_direction

   task automatic t_feed;
      od(1'b1, 16'h60ee, 8'h02, 32'h4, 1'b0);
      feed(2'h2, 32'h64);
      `CHK({feedDone, feedConstant}, {1'b1, 32'h19})
      feed(2'h0, 32'h64);
      `CHK({feedSkipped, feedConstant}, {1'b1, 32'h19})
      $display("feed test done");
   endtask : t_feed

   task automatic complete_run;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (16) @(negedge clock);
      resetn <= 1'b1;
      t_registers;
      t_relative;
      t_release;
      t_direction;
      t_feed;
      complete_run;
   end

   // The whole sequence needs well under 2000 cycles.
   initial begin
      #200000;
      n_errors++;
      complete_run;
   end
endmodule : test_positioning_option_decoder

`default_nettype wire
